// ### dv/trigger_source_model.sv
/*
 * Source model: external trigger lines, core thread events, perf counters.
 * Assumes the bench calls its tasks from one process, right after a clock edge.
 */
`timescale 1ns/10ps
module trigger_source_model
    import trigger_status_router_pkg::*;
(
    // clock
    input wire logic clk,
    // source levels toward the router
    output logic [31:0] ext_trig,
    output thread_events_t thread_evt,
    output perf_counts_t perf_count
);
    // all quiet at time zero, so no rise is seen at reset release
    initial begin
        ext_trig = '0;
        thread_evt = '0;
        perf_count = '0;
    end
    // one external line to a level; a pulse is two calls
    task set_ext(input int j, input logic v);
        @(posedge clk);
        ext_trig[j] <= v;
    endtask : set_ext
    // one-cycle high on flattened thread event bit i
    task pulse_evt(input int i);
        @(posedge clk);
        thread_evt[i] <= 1'b1;
        @(posedge clk);
        thread_evt[i] <= 1'b0;
    endtask : pulse_evt
    // both counters pass all-ones then zero
    task wrap();
        @(posedge clk);
        perf_count <= '1;
        @(posedge clk);
        perf_count <= '0;
    endtask : wrap
endmodule : trigger_source_model

// ### dv/trigger_status_router_asserts.sv
/*
 * Port checker of the trigger status router.
 * Assumes a bind from the bench top file; sees only the top module's ports.
 */
`timescale 1ns/10ps
`include "trigger_status_router_params.svh"
module trigger_status_router_asserts
    import trigger_status_router_pkg::*;
#(
    parameter int NUM_EXT = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register bus
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata_q,
    input wire logic waitrequest_q,
    // sources and destinations
    input wire logic [NUM_EXT-1:0] ext_trig,
    input wire thread_events_t thread_evt,
    input wire logic [11:0] core_trig_q,
    input wire logic dbg_view_q,
    input wire logic slave_view_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // source history, reset like the design's so rises line up
    logic [NUM_EXT-1:0] ext_q;
    logic [11:0] evt_q;
    // any cause of a status change, last three edges
    logic [2:0] cause_q;
    logic rise;
    logic acc;
    assign rise = |(ext_trig & ~ext_q) || |(thread_evt & ~evt_q);
    assign acc = write && !waitrequest_q;
    // history shift
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_q <= '0;
            evt_q <= '0;
            cause_q <= '0;
        end else begin
            ext_q <= ext_trig;
            evt_q <= thread_evt;
            cause_q <= {cause_q[1:0], acc || rise || (ext_trig != ext_q)};
        end
    end
    property p_wait_one;
        !waitrequest_q |=> waitrequest_q;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low twice");
    property p_wait_cause;
        $fell(waitrequest_q) |-> $past(read || write);
    endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
    property p_answer;
        (read || write) |-> ##[0:1] !waitrequest_q;
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    property p_rdata_hold;
        !read |=> $stable(readdata_q);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_reserved;
        read && !waitrequest_q && address == `TSR_ADDR_CORE_STATUS
            |-> (readdata_q & ~`TSR_CORE_STATUS_MASK) == 32'h0000_0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");
    property p_pulse_cause;
        |core_trig_q |-> $past(rise) || $past(acc) || $past(acc, 2);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("stray pulse");
    property p_dbg_cause;
        $changed(dbg_view_q) |-> |cause_q;
    endproperty
    a_dbg_cause: assert property (p_dbg_cause) else $error("debug view moved");
    property p_slave_cause;
        $changed(slave_view_q) |-> |cause_q;
    endproperty
    a_slave_cause: assert property (p_slave_cause) else $error("slave view moved");
    // main scenarios reached
    c_pulse: cover property (|core_trig_q);
    c_dbg: cover property ($rose(dbg_view_q));
    c_slave: cover property ($rose(slave_view_q));
endmodule : trigger_status_router_asserts

// ### dv/trigger_status_router_tb.sv
/*
 * Self-checking bench of the trigger status router.
 * Assumes the source model and checker are compiled before this file.
 */
`timescale 1ns/10ps
`include "trigger_status_router_params.svh"
module trigger_status_router_tb
    import trigger_status_router_pkg::*;
;
    // bus and sideband driven here, plus the uut outputs and the src sources
    logic clk, nrst, read, write, waitrequest_q, req_priv, dbg_view_q, slave_view_q;
    logic [31:0] address, writedata, readdata_q, ext_trig;
    logic [3:0] byteenable;
    logic [1:0] req_thread;
    logic [11:0] core_trig_q;
    thread_events_t thread_evt;
    perf_counts_t perf_count;
    // tallies
    int failures;
    int n_compared;
    int pc [12];
    trigger_status_router uut (.clk(clk), .nrst(nrst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata_q(readdata_q), .waitrequest_q(waitrequest_q), .req_thread(req_thread),
        .req_priv(req_priv), .ext_trig(ext_trig), .thread_evt(thread_evt),
        .perf_count(perf_count), .core_trig_q(core_trig_q), .dbg_view_q(dbg_view_q),
        .slave_view_q(slave_view_q));
    trigger_source_model src (.clk(clk), .ext_trig(ext_trig), .thread_evt(thread_evt),
        .perf_count(perf_count));
    // clock, 50 ns
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // count pulses per core trigger line
    always @(posedge clk) begin
        for (int i = 0; i < 12; i++) begin
            if (core_trig_q[i] === 1'b1)
                pc[i]++;
        end
    end
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // one request, held until waitrequest is seen low at an edge
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        // no cycle count assumed; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (waitrequest_q !== 1'b0);
        q = readdata_q;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        cmp(q, exp);
    endtask : rd
    // let pulses and views settle
    task idle();
        repeat (4) @(posedge clk);
    endtask : idle
    task pulse(input int j);
        src.set_ext(j, 1'b1);
        src.set_ext(j, 1'b0);
        idle();
    endtask : pulse
    task t_reset();
        rd(`TSR_ADDR_CORE_STATUS, 32'h0000_0000);
        rd(`TSR_ADDR_EXT_STATUS, 32'h0000_0000);
        rd(`TSR_ADDR_EXT_MODE, 32'h0000_0000);
        rd(`TSR_ADDR_EXT_VEC, 32'h0000_0000);
        rd(`TSR_ADDR_PRIV_MASK, 32'h0000_000B);
        rd(32'h0482_0FF0, 32'h0000_0000);
        $display("reset values done");
    endtask : t_reset
    task t_edge();
        // vectors: t0=5 t1=6 t2=0 t3=1 t4=2 t5=3
        wr(`TSR_ADDR_EXT_VEC, 32'h0032_1065);
        rd(`TSR_ADDR_EXT_VEC, 32'h0032_1065);
        pulse(0);
        cmp(32'(pc[1]), 32'h0000_0001);
        pulse(0);
        rd(`TSR_ADDR_EXT_STATUS, 32'h0000_0001);
        wr(`TSR_ADDR_EXT_STATUS, 32'h0000_0001);
        rd(`TSR_ADDR_EXT_STATUS, 32'h0000_0000);
        wr(`TSR_ADDR_EXT_STATUS, 32'h0000_0001);
        idle();
        cmp(32'(pc[1]), 32'h0000_0003);
        rd(`TSR_ADDR_EXT_STATUS, 32'h0000_0001);
        pulse(2);
        rd(`TSR_ADDR_EXT_STATUS, 32'h0000_0005);
        cmp(32'(pc[0] + pc[2] + pc[3]), 32'h0000_0000);
        wr(`TSR_ADDR_EXT_STATUS, 32'h0000_0005);
        $display("edge model done");
    endtask : t_edge
    task t_level();
        wr(`TSR_ADDR_EXT_MODE, 32'h0000_0002);
        src.set_ext(1, 1'b1);
        idle();
        rd(`TSR_ADDR_EXT_STATUS, 32'h0000_0002);
        cmp(32'(pc[2]), 32'h0000_0001);
        src.set_ext(1, 1'b0);
        idle();
        rd(`TSR_ADDR_EXT_STATUS, 32'h0000_0000);
        wr(`TSR_ADDR_EXT_STATUS, 32'h0000_0002);
        idle();
        cmp(32'(pc[2]), 32'h0000_0002);
        wr(`TSR_ADDR_EXT_MODE, 32'h0000_0000);
        $display("level model done");
    endtask : t_level
    task t_views();
        pulse(3);
        cmp(32'(dbg_view_q), 32'h0000_0001);
        cmp(32'(slave_view_q), 32'h0000_0000);
        wr(`TSR_ADDR_EXT_STATUS, 32'h0000_0008);
        idle();
        cmp(32'(dbg_view_q), 32'h0000_0000);
        for (int j = 4; j < 6; j++) begin
            pulse(j);
            cmp(32'(slave_view_q), 32'h0000_0001);
            wr(`TSR_ADDR_EXT_STATUS, 32'h0000_0001 << j);
            idle();
            cmp(32'(slave_view_q), 32'h0000_0000);
        end
        $display("views done");
    endtask : t_views
    task t_core();
        wr(32'h0482_0568, 32'h0000_000B);
        wr(32'h0482_0570, 32'h0000_000F);
        for (int i = 0; i < 12; i++)
            src.pulse_evt(i);
        src.wrap();
        idle();
        cmp(32'(pc[7]), 32'h0000_0001);
        cmp(32'(pc[11]), 32'h0000_0001);
        rd(`TSR_ADDR_CORE_STATUS, 32'h0003_7777);
        wr(`TSR_ADDR_CORE_STATUS, 32'hFFFF_FFFF);
        rd(`TSR_ADDR_CORE_STATUS, 32'h0000_0000);
        wr(`TSR_ADDR_CORE_STATUS, 32'hFFFF_FFFF);
        idle();
        rd(`TSR_ADDR_CORE_STATUS, 32'h0003_7777);
        cmp(32'(pc[7]), 32'h0000_0002);
        cmp(32'(pc[11]), 32'h0000_0002);
        wr(`TSR_ADDR_CORE_STATUS, 32'h0003_7777);
        $display("core status done");
    endtask : t_core
    task t_priv();
        req_priv <= 1'b0;
        rd(`TSR_ADDR_PRIV_MASK, 32'h0000_0000);
        wr(`TSR_ADDR_PRIV_MASK, 32'h0000_0000);
        req_priv <= 1'b1;
        rd(`TSR_ADDR_PRIV_MASK, 32'h0000_000B);
        wr(32'h0481_0108, 32'h0000_000F);
        req_priv <= 1'b0;
        req_thread <= 2'd1;
        rd(`TSR_ADDR_EXT_VEC, 32'h0000_0000);
        wr(`TSR_ADDR_EXT_MODE, 32'h0000_0001);
        req_thread <= 2'd0;
        rd(`TSR_ADDR_EXT_VEC, 32'h0032_1065);
        rd(`TSR_ADDR_EXT_MODE, 32'h0000_0000);
        req_priv <= 1'b1;
        $display("privilege done");
    endtask : t_priv
    task summarize();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    // hang guard, well past the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        summarize();
    end
    // main sequence
    initial begin
        nrst = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 32'h0000_0000;
        writedata = 32'h0000_0000;
        byteenable = 4'hF;
        req_thread = 2'd0;
        req_priv = 1'b1;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset();
        t_edge();
        t_level();
        t_views();
        t_core();
        t_priv();
        summarize();
    end
endmodule : trigger_status_router_tb
bind trigger_status_router trigger_status_router_asserts #(.NUM_EXT(NUM_EXT)) u_chk (
    .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .readdata_q(readdata_q), .waitrequest_q(waitrequest_q), .ext_trig(ext_trig),
    .thread_evt(thread_evt), .core_trig_q(core_trig_q), .dbg_view_q(dbg_view_q),
    .slave_view_q(slave_view_q));

// ### logic/trigger_status_router.sv
/*
 * Trigger status router: latches core and external trigger sources, lets software
 * toggle or raise them, and routes each one by its vector to the core trigger inputs,
 * the debug view or the slave view. Registers sit on an Avalon-MM slave with waitrequest.
 * Assumes all inputs are synchronous to clk, and that the bus sideband names the
 * requesting thread and its privilege for the whole request.
 */
`timescale 1ns/10ps
`include "trigger_status_router_params.svh"

// Notes on behaviour
// - edge model: hardware edge sets bit, forwards
// - edge model: software one toggles the bit
// - simultaneous toggle and hardware edge gives one
// - zero-to-one write sends edge if vector nonzero
// - level model: read returns live source level
// - level model: each rise sends one event
// - level model: software one sends a trigger
// - four-bit vector, zero suppresses delivery
// - vectors 4..15 pulse core trigger inputs
// - vector 1 shows trigger to debug port
// - vectors 2 and 3 show trigger to slave
// - bit 16 records counter zero roll-over
// - bit 17 records counter one roll-over
// - threads 1..3 fault/irq/background at their nibbles
// - privilege mask blocks unprivileged 64 KB slices
// - thread 0 fault/irq/background at bits 2..0
// - core status bits always use edge model
// - mode bit one selects level, zero edge
module trigger_status_router
    import trigger_status_router_pkg::*;
#(
    parameter int NUM_EXT = 32,
    parameter int PERF_WIDTH = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // avalon-mm register slave
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata_q,
    output logic waitrequest_q,
    // requester sideband, held with the request
    input wire logic [1:0] req_thread,
    input wire logic req_priv,
    // trigger sources
    input wire logic [NUM_EXT-1:0] ext_trig,
    input wire thread_events_t thread_evt,
    input wire perf_counts_t perf_count,
    // trigger destinations
    output logic [11:0] core_trig_q,
    output logic dbg_view_q,
    output logic slave_view_q
);

    localparam int NT = 12 + NUM_EXT; // 12 thread triggers, then the external ones
    localparam int EXT_WORDS = (NUM_EXT + 7) / 8; // eight vector nibbles per word

    // refuse sizes the register layout cannot hold
    if (NUM_EXT < 1 || NUM_EXT > 32) begin : g_bad_ext
        $error("NUM_EXT must lie in 1..32");
    end
    if (PERF_WIDTH != 24) begin : g_bad_perf
        $error("PERF_WIDTH must be 24");
    end

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge_word(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old_w & ~m) | (new_w & m);
    endfunction : merge_word

    bus_state_t state_q; // bus handshake state
    bus_state_t state_d;
    logic [31:0] cts_q; // core trigger status
    logic [31:0] cts_d;
    logic [NUM_EXT-1:0] ext_stat_q; // external status, edge model bits
    logic [NUM_EXT-1:0] ext_stat_d;
    logic [NUM_EXT-1:0] ext_mode_q; // external mode select
    logic [3:0] vec_q [NT]; // trigger vectors, thread ones first
    logic [31:0] priv_q [4]; // per-thread core privilege masks
    logic [NUM_EXT-1:0] ext_prev_q; // last external levels
    logic [11:0] thr_prev_q; // last thread source levels
    logic perf0_ones_q; // counter zero was all ones
    logic perf1_ones_q; // counter one was all ones

    logic [31:0] wmask; // byte enables as bit mask
    logic [31:0] wdata_m; // write data, disabled lanes cleared
    logic blocked; // request refused by privilege
    logic wr_ok; // write takes effect this edge
    logic hit_cts;
    logic hit_ext_stat;
    logic hit_ext_mode;
    logic [11:0] hit_tvec;
    logic [3:0] hit_evec;
    logic [3:0] hit_priv;
    logic [11:0] thr_lvl; // thread sources, index 3*t+k
    logic [11:0] thr_rise;
    logic [NUM_EXT-1:0] ext_rise;
    logic perf0_wrap;
    logic perf1_wrap;
    logic [31:0] sw_cts; // software toggle of core status
    logic [NUM_EXT-1:0] sw_ext; // software ones to external status
    logic [NUM_EXT-1:0] ext_view; // external status as software sees it
    logic [NT-1:0] evt; // raw trigger events, before the vector
    logic [NT-1:0] stat_view; // trigger status per index
    logic [11:0] core_trig_d;
    logic dbg_view_d;
    logic slave_view_d;
    logic [31:0] rd_word;

    assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                    {8{byteenable[1]}}, {8{byteenable[0]}}};
    assign wdata_m = writedata & wmask;

    // unprivileged access to a masked 64 KB slice of the core region is refused
    assign blocked = !req_priv && (address[31:20] == `TSR_CORE_REGION)
                     && priv_q[req_thread][address[19:16]];
    assign wr_ok = write && (state_q == BUS_DONE) && !blocked;

    // address decode; bits 1:0 are ignored, accesses are whole words
    always_comb begin
        hit_cts = (address[31:2] == 30'(`TSR_ADDR_CORE_STATUS >> 2));
        hit_ext_stat = (address[31:2] == 30'(`TSR_ADDR_EXT_STATUS >> 2));
        hit_ext_mode = (address[31:2] == 30'(`TSR_ADDR_EXT_MODE >> 2));
        for (int t = 0; t < 4; t++) begin
            for (int k = 0; k < 3; k++) begin
                hit_tvec[3*t+k] = (address[31:2] == 30'((`TSR_ADDR_THREAD_VEC
                    + 32'(t) * `TSR_THREAD_VEC_STRIDE + 32'(k) * `TSR_KIND_VEC_STRIDE) >> 2));
            end
            hit_priv[t] = (address[31:2] == 30'((`TSR_ADDR_PRIV_MASK
                + 32'(t) * `TSR_PRIV_STRIDE) >> 2));
        end
        for (int w = 0; w < 4; w++) begin
            hit_evec[w] = (w < EXT_WORDS) && (address[31:2] == 30'((`TSR_ADDR_EXT_VEC
                + 32'(w) * `TSR_EXT_VEC_STRIDE) >> 2));
        end
    end

    // hardware source edges and counter wraps
    always_comb begin
        for (int t = 0; t < 4; t++) begin
            thr_lvl[3*t] = thread_evt.background[t];
            thr_lvl[3*t+1] = thread_evt.irq[t];
            thr_lvl[3*t+2] = thread_evt.fault[t];
        end
        thr_rise = thr_lvl & ~thr_prev_q;
        ext_rise = ext_trig & ~ext_prev_q;
        perf0_wrap = perf0_ones_q && (perf_count.zero == '0);
        perf1_wrap = perf1_ones_q && (perf_count.one == '0);
    end

    // core status: toggle by software, set by hardware, set wins; always edge model
    always_comb begin
        sw_cts = (wr_ok && hit_cts) ? (wdata_m & `TSR_CORE_STATUS_MASK) : 32'h0000_0000;
        cts_d = cts_q ^ sw_cts;
        for (int t = 0; t < 4; t++) begin
            for (int k = 0; k < 3; k++) begin
                if (thr_rise[3*t+k]) begin
                    cts_d[`TSR_THREAD_FIELD*t+k] = 1'b1;
                end
            end
        end
        if (perf0_wrap) begin
            cts_d[`TSR_PERF0_BIT] = 1'b1;
        end
        if (perf1_wrap) begin
            cts_d[`TSR_PERF1_BIT] = 1'b1;
        end
        cts_d = cts_d & `TSR_CORE_STATUS_MASK;
    end

    // external status: edge bits latch, level bits leave the stored value alone
    always_comb begin
        sw_ext = (wr_ok && hit_ext_stat) ? wdata_m[NUM_EXT-1:0] : '0;
        ext_stat_d = (~ext_mode_q & ((ext_stat_q ^ sw_ext) | ext_rise))
                     | (ext_mode_q & ext_stat_q);
        ext_view = (ext_mode_q & ext_trig) | (~ext_mode_q & ext_stat_q);
    end

    // events per trigger and the status that the views show
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            evt[i] = 1'b0;
            stat_view[i] = 1'b0;
        end
        for (int t = 0; t < 4; t++) begin
            for (int k = 0; k < 3; k++) begin
                // hardware edge, or software one written over a zero
                evt[3*t+k] = thr_rise[3*t+k]
                    || (sw_cts[`TSR_THREAD_FIELD*t+k] && !cts_q[`TSR_THREAD_FIELD*t+k]);
                stat_view[3*t+k] = cts_q[`TSR_THREAD_FIELD*t+k];
            end
        end
        for (int j = 0; j < NUM_EXT; j++) begin
            if (ext_mode_q[j]) begin
                evt[12+j] = ext_rise[j] || sw_ext[j];
            end else begin
                evt[12+j] = ext_rise[j] || (sw_ext[j] && !ext_stat_q[j]);
            end
            stat_view[12+j] = ext_view[j];
        end
    end

    // routing by vector: core pulses, debug and slave views
    always_comb begin
        core_trig_d = 12'h000;
        dbg_view_d = 1'b0;
        slave_view_d = 1'b0;
        for (int i = 0; i < NT; i++) begin
            // a zero vector matches none of the branches below
            if (evt[i] && (vec_q[i] >= `TSR_VEC_CORE_FIRST)) begin
                core_trig_d[4'(vec_q[i] - `TSR_VEC_CORE_FIRST)] = 1'b1;
            end
            if (stat_view[i] && (vec_q[i] == `TSR_VEC_DEBUG)) begin
                dbg_view_d = 1'b1;
            end
            if (stat_view[i] && ((vec_q[i] == `TSR_VEC_SLAVE_LO)
                                 || (vec_q[i] == `TSR_VEC_SLAVE_HI))) begin
                slave_view_d = 1'b1;
            end
        end
    end

    // read mux; unmapped and refused reads return zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_cts) begin
            rd_word = cts_q & `TSR_CORE_STATUS_MASK;
        end
        if (hit_ext_stat) begin
            rd_word[NUM_EXT-1:0] = ext_view;
        end
        if (hit_ext_mode) begin
            rd_word[NUM_EXT-1:0] = ext_mode_q;
        end
        for (int i = 0; i < 12; i++) begin
            if (hit_tvec[i]) begin
                rd_word[3:0] = vec_q[i];
            end
        end
        for (int w = 0; w < 4; w++) begin
            for (int n = 0; n < 8; n++) begin
                if (hit_evec[w] && (8*w + n < NUM_EXT)) begin
                    rd_word[4*n +: 4] = vec_q[12 + 8*w + n];
                end
            end
        end
        for (int t = 0; t < 4; t++) begin
            if (hit_priv[t]) begin
                rd_word = priv_q[t];
            end
        end
        if (blocked) begin
            rd_word = 32'h0000_0000;
        end
    end

    // bus handshake: one wait state, then the request is taken
    always_comb begin
        case (state_q)
            BUS_IDLE: state_d = (read || write) ? BUS_DONE : BUS_IDLE;
            BUS_DONE: state_d = BUS_IDLE;
            default: state_d = BUS_IDLE;
        endcase
    end

    // handshake registers; read data captured one edge before acceptance
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= BUS_IDLE;
            waitrequest_q <= 1'b1;
            readdata_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            waitrequest_q <= (state_d != BUS_DONE);
            if (state_q == BUS_IDLE && read) begin
                readdata_q <= rd_word;
            end
        end
    end

    // trigger status registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cts_q <= `TSR_CORE_STATUS_RESET;
            ext_stat_q <= '0;
        end else begin
            cts_q <= cts_d;
            ext_stat_q <= ext_stat_d;
        end
    end

    // configuration: mode select, vectors, privilege masks
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_mode_q <= '0;
            for (int i = 0; i < NT; i++) begin
                vec_q[i] <= `TSR_VEC_RESET;
            end
            for (int t = 0; t < 4; t++) begin
                priv_q[t] <= `TSR_PRIV_MASK_RESET;
            end
        end else if (wr_ok) begin
            if (hit_ext_mode) begin
                ext_mode_q <= NUM_EXT'(merge_word(32'(ext_mode_q), writedata, byteenable));
            end
            for (int i = 0; i < 12; i++) begin
                if (hit_tvec[i] && byteenable[0]) begin
                    vec_q[i] <= writedata[3:0];
                end
            end
            for (int w = 0; w < 4; w++) begin
                for (int n = 0; n < 8; n++) begin
                    if (hit_evec[w] && (8*w + n < NUM_EXT) && byteenable[n/2]) begin
                        vec_q[12 + 8*w + n] <= writedata[4*n +: 4];
                    end
                end
            end
            for (int t = 0; t < 4; t++) begin
                if (hit_priv[t]) begin
                    priv_q[t] <= merge_word(priv_q[t], writedata, byteenable);
                end
            end
        end
    end

    // source history for edge and wrap detection
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_prev_q <= '0;
            thr_prev_q <= 12'h000;
            perf0_ones_q <= 1'b0;
            perf1_ones_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_trig;
            thr_prev_q <= thr_lvl;
            perf0_ones_q <= &perf_count.zero;
            perf1_ones_q <= &perf_count.one;
        end
    end

    // destinations; core pulses last exactly one cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            core_trig_q <= 12'h000;
            dbg_view_q <= 1'b0;
            slave_view_q <= 1'b0;
        end else begin
            core_trig_q <= core_trig_d;
            dbg_view_q <= dbg_view_d;
            slave_view_q <= slave_view_d;
        end
    end

endmodule : trigger_status_router

// ### logic/trigger_status_router_params.svh
/*
 * Address map, field positions and reset values of the trigger status router.
 * Assumes byte addresses on a 32-bit register bus, one register per aligned word.
 */
`ifndef TRIGGER_STATUS_ROUTER_PARAMS_SVH
`define TRIGGER_STATUS_ROUTER_PARAMS_SVH

// register byte addresses
`define TSR_ADDR_CORE_STATUS 32'h0482_0000
`define TSR_ADDR_EXT_STATUS 32'h0482_0010
`define TSR_ADDR_EXT_MODE 32'h0482_0030
`define TSR_ADDR_THREAD_VEC 32'h0482_0500
`define TSR_THREAD_VEC_STRIDE 32'h0000_0020
`define TSR_KIND_VEC_STRIDE 32'h0000_0008
`define TSR_ADDR_EXT_VEC 32'h0482_0600
`define TSR_EXT_VEC_STRIDE 32'h0000_0004
`define TSR_ADDR_PRIV_MASK 32'h0481_0100
`define TSR_PRIV_STRIDE 32'h0000_0008

// core register region, address bits 31:20, sliced by bits 19:16
`define TSR_CORE_REGION 12'h048

// reset values
`define TSR_CORE_STATUS_RESET 32'h0000_0000
`define TSR_EXT_RESET 32'h0000_0000
`define TSR_PRIV_MASK_RESET 32'h0000_000B
`define TSR_VEC_RESET 4'h0

// core status layout: thread t, kind k at bit 4*t+k; perf roll-overs at 16 and 17
`define TSR_CORE_STATUS_MASK 32'h0003_7777
`define TSR_THREAD_FIELD 4
`define TSR_PERF0_BIT 16
`define TSR_PERF1_BIT 17

// trigger vector values
`define TSR_VEC_DEBUG 4'h1
`define TSR_VEC_SLAVE_LO 4'h2
`define TSR_VEC_SLAVE_HI 4'h3
`define TSR_VEC_CORE_FIRST 4'h4

`endif

// ### logic/trigger_status_router_pkg.sv
/*
 * Types shared by the trigger status router and its surroundings.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package trigger_status_router_pkg;

    // bus handshake states, gray along idle -> done -> idle
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_DONE = 1'b1
    } bus_state_t;

    // per-thread trigger sources from the core, index is the thread
    typedef struct packed {
        logic [3:0] fault;
        logic [3:0] irq;
        logic [3:0] background;
    } thread_events_t;

    // the two performance counter values watched for roll-over
    typedef struct packed {
        logic [23:0] one;
        logic [23:0] zero;
    } perf_counts_t;

endpackage : trigger_status_router_pkg
